//--- src/adcseq_defs.svh
// Register map, field positions, reset values and timing counts of the converter sequencer
// Function
// (R1) Timing register bit 7 set gives a right-justified result, cleared gives left-justified.
// (R2) Acquisition code selects 0,2,4,6,8,12,16 or 20 bit periods.
// (R3) Clock code selects oscillator over 2,8,32,4,16,64, or the RC clock.
// (R4) With the RC clock selected, wait one instruction cycle before it starts.
// (R5) Timing register bit 6 always reads zero and ignores writes.
// (R6) Reset restores registers, switches the converter off and aborts conversion.
// (R7) On completion load the result, clear go and set the complete flag.
// (R8) Power-on reset leaves the result pair untouched.
// (R9) Two bit periods pass after a conversion before acquisition begins again.
// (R10) Nonzero acquisition code samples for the programmed time, then converts automatically.
// (R11) Acquisition code zero stops sampling at once and converts.
// (R12) In manual mode software times acquisition before setting go.
// (R13) After each conversion sampling of the selected channel resumes.
// (R14) No status separates acquisition from conversion; go stays set through both.
// (R15) The sampling switch opens when conversion starts and stays open throughout.
// (R16) Successive approximation resolves one bit per bit period.
// (R17) Software selects the RC clock for conversions during sleep.
// (R18) Software configures, enables, sets go, then polls or awaits the flag.
// (R19) Software selects supply rails or external pins as references.
// (R20) A full conversion lasts eleven bit periods beyond acquisition.
// (R21) Clearing go during conversion aborts it and keeps the old result.
// (R22) Enable bit switches the converter on; go reads busy only when enabled.
// (R23) Four-bit channel field selects channels 0 to 12.
// (R24) Left format: high holds top eight bits; right: high holds top two.
// (R25) Go set while disabled starts nothing.
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

`define ADCSEQ_ADDR_W          3
`define ADCSEQ_OFS_RES_HIGH    3'h0
`define ADCSEQ_OFS_RES_LOW     3'h1
`define ADCSEQ_OFS_CTRL_MAIN   3'h2
`define ADCSEQ_OFS_REF_PIN     3'h3
`define ADCSEQ_OFS_TIMING      3'h4
`define ADCSEQ_OFS_FLAGS       3'h5

`define ADCSEQ_BIT_ENABLE      0
`define ADCSEQ_BIT_GO          1
`define ADCSEQ_POS_CHAN        2
`define ADCSEQ_BIT_VREF_POS    4
`define ADCSEQ_BIT_VREF_NEG    5
`define ADCSEQ_POS_CLK_SEL     0
`define ADCSEQ_POS_ACQ_SEL     3
`define ADCSEQ_BIT_RJUST       7
`define ADCSEQ_BIT_FLAG        0
`define ADCSEQ_BIT_IRQ_EN      1

`define ADCSEQ_RST_CTRL        8'h00
`define ADCSEQ_RST_REF_PIN     8'h00
`define ADCSEQ_RST_TIMING      8'h00

`define ADCSEQ_CLK_PERIOD_NS   20
`define ADCSEQ_TCY_NS          80
`define ADCSEQ_TCY_CYCLES      ((`ADCSEQ_TCY_NS + `ADCSEQ_CLK_PERIOD_NS - 1) / `ADCSEQ_CLK_PERIOD_NS)
`define ADCSEQ_CONV_TADS       11
`define ADCSEQ_HOLDOFF_TADS    2

`endif

//--- src/adcseq_pkg.sv
// Types shared by the converter sequencer
package adcseq_pkg;
	// One-hot sequencer states
	typedef enum logic [4:0] {
		ST_SAMPLE  = 5'b0_0001,
		ST_RC_WAIT = 5'b0_0010,
		ST_ACQ     = 5'b0_0100,
		ST_CONV    = 5'b0_1000,
		ST_HOLDOFF = 5'b1_0000
	} adcseq_state_type;
endpackage

//--- src/adcseq_tad_gen.sv
// Conversion bit period tick generator
`timescale 1ns/1ps
module adcseq_tad_gen (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       run_i,
	input  wire logic [2:0] clk_sel_i,
	input  wire logic       rc_tick_i,
	output logic            tick_o
);
	logic [6:0] div_q;
	logic [6:0] div_d;
	logic       rc_sel;
	logic       div_wrap;

	// Oscillator divide ratio per clock code
	function automatic logic [6:0] div_ratio(input logic [2:0] sel);
		case (sel)
			3'b000:  div_ratio = 7'd2;
			3'b001:  div_ratio = 7'd8;
			3'b010:  div_ratio = 7'd32;
			3'b100:  div_ratio = 7'd4;
			3'b101:  div_ratio = 7'd16;
			3'b110:  div_ratio = 7'd64;
			default: div_ratio = 7'd2;
		endcase
	endfunction

	// Codes x11 pick the RC clock, else divide the oscillator
	assign rc_sel   = (clk_sel_i[1:0] == 2'b11); // R3
	assign div_wrap = (div_q == div_ratio(clk_sel_i) - 7'd1);
	assign div_d    = (!run_i || div_wrap) ? 7'd0 : div_q + 7'd1;
	assign tick_o   = run_i && (rc_sel ? rc_tick_i : div_wrap); // R3

	// Divider restarts whenever the sequencer stops
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			div_q <= 7'd0;
		else
			div_q <= div_d;
	end
endmodule // adcseq_tad_gen

//--- src/adcseq_sar.sv
// Successive approximation engine, one bit per bit period
`timescale 1ns/1ps
`include "adcseq_defs.svh"
module adcseq_sar (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       start_i,
	input  wire logic       abort_i,
	input  wire logic       tick_i,
	input  wire logic       comp_i,
	output logic [9:0]      dac_code_o,
	output logic            done_o
);
	logic       busy_q;
	logic [3:0] step_q;
	logic [9:0] code_q;
	logic [9:0] trial_bit;
	logic       last_step;

	// First period settles the hold, ten more resolve bits
	assign trial_bit  = 10'h200 >> (step_q - 4'd1);
	assign last_step  = (step_q == 4'(`ADCSEQ_CONV_TADS - 1)); // R20
	assign done_o     = busy_q && tick_i && last_step;
	assign dac_code_o = code_q;

	// Keep the trial bit when the comparator says input is above it
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			busy_q <= 1'b0;
			step_q <= 4'd0;
			code_q <= 10'h000;
		end
		else if (abort_i)
			busy_q <= 1'b0;
		else if (start_i)
		begin
			busy_q <= 1'b1;
			step_q <= 4'd0;
			code_q <= 10'h200;
		end
		else if (busy_q && tick_i)
		begin
			step_q <= step_q + 4'd1;
			if (step_q != 4'd0)
				code_q <= (comp_i ? code_q : code_q & ~trial_bit) | (trial_bit >> 1); // R16
			if (last_step)
				busy_q <= 1'b0;
		end
	end
endmodule // adcseq_sar

//--- src/adcseq_top.sv
// Converter acquisition and conversion sequencer with its register file
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "adcseq_defs.svh"
module adcseq_top (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic [2:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic [7:0]      reg_rdata_o,
	input  wire logic       rc_tick_i,
	input  wire logic       comp_i,
	output logic [9:0]      dac_code_o,
	output logic [3:0]      channel_select_o,
	output logic            sample_closed_o,
	output logic            converter_enable_o,
	output logic            vref_pos_ext_o,
	output logic            vref_neg_ext_o,
	output logic [3:0]      pin_cfg_o,
	output logic            conv_complete_flag_o,
	output logic            conv_complete_irq_en_o
);
	adcseq_pkg::adcseq_state_type state_q;
	adcseq_pkg::adcseq_state_type state_d;

	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] refpin_q;
	logic [7:0] timing_q;
	logic       flag_q;
	logic       flag_d;
	logic       irq_en_q;
	logic [7:0] res_high_q;
	logic [7:0] res_low_q;
	logic [7:0] rdata_q;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;

	logic       enable;
	logic       go;
	logic       rjust;
	logic [2:0] acq_sel;
	logic [2:0] clk_sel;
	logic       rc_sel;
	logic [4:0] acq_tads;
	logic       tad_tick;
	logic       tad_run;
	logic       sar_start;
	logic       sar_abort;
	logic       sar_done;
	logic [9:0] sar_code;
	logic [9:0] sar_result;
	logic [7:0] res_high_new;
	logic [7:0] res_low_new;
	logic [7:0] rd_mux;
	logic       wr_ctrl;
	logic       wr_flags;
	logic       wr_high;
	logic       wr_low;
	logic       st_sample;
	logic       st_rc;
	logic       st_acq;
	logic       st_conv;
	logic       st_hold;

	// Acquisition length in bit periods per code
	function automatic logic [4:0] acq_len(input logic [2:0] code);
		case (code)
			3'b000:  acq_len = 5'd0;
			3'b001:  acq_len = 5'd2;
			3'b010:  acq_len = 5'd4;
			3'b011:  acq_len = 5'd6;
			3'b100:  acq_len = 5'd8;
			3'b101:  acq_len = 5'd12;
			3'b110:  acq_len = 5'd16;
			default: acq_len = 5'd20;
		endcase
	endfunction

	// Field decode
	assign enable   = ctrl_q[`ADCSEQ_BIT_ENABLE];
	assign go       = ctrl_q[`ADCSEQ_BIT_GO];
	assign rjust    = timing_q[`ADCSEQ_BIT_RJUST];
	assign acq_sel  = timing_q[`ADCSEQ_POS_ACQ_SEL +: 3];
	assign clk_sel  = timing_q[`ADCSEQ_POS_CLK_SEL +: 3];
	assign rc_sel   = (clk_sel[1:0] == 2'b11);
	assign acq_tads = acq_len(acq_sel); // R2

	// Address decode for writes
	assign wr_ctrl  = reg_wr_i && (reg_addr_i == `ADCSEQ_OFS_CTRL_MAIN);
	assign wr_flags = reg_wr_i && (reg_addr_i == `ADCSEQ_OFS_FLAGS);
	assign wr_high  = reg_wr_i && (reg_addr_i == `ADCSEQ_OFS_RES_HIGH);
	assign wr_low   = reg_wr_i && (reg_addr_i == `ADCSEQ_OFS_RES_LOW);

	// State shorthands
	assign st_sample = (state_q == adcseq_pkg::ST_SAMPLE);
	assign st_rc     = (state_q == adcseq_pkg::ST_RC_WAIT);
	assign st_acq    = (state_q == adcseq_pkg::ST_ACQ);
	assign st_conv   = (state_q == adcseq_pkg::ST_CONV);
	assign st_hold   = (state_q == adcseq_pkg::ST_HOLDOFF);

	// Analog side: switch is open from conversion start to resampling
	assign sample_closed_o    = enable && (st_sample || st_acq || (st_rc && acq_sel != 3'b000)); // R15 R11 R13
	assign converter_enable_o = enable; // R22
	assign channel_select_o   = ctrl_q[`ADCSEQ_POS_CHAN +: 4]; // R23
	assign vref_pos_ext_o     = refpin_q[`ADCSEQ_BIT_VREF_POS]; // R19
	assign vref_neg_ext_o     = refpin_q[`ADCSEQ_BIT_VREF_NEG]; // R19
	assign pin_cfg_o          = refpin_q[3:0];
	assign conv_complete_flag_o   = flag_q;
	assign conv_complete_irq_en_o = irq_en_q;
	assign reg_rdata_o        = rdata_q;

	// Bit period clock runs only while a timed phase is active
	assign tad_run = st_acq || st_conv || st_hold;

	adcseq_tad_gen u_tad_gen (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.run_i     (tad_run),
		.clk_sel_i (clk_sel),
		.rc_tick_i (rc_tick_i),
		.tick_o    (tad_tick)
	);

	// Sequencer next state; clearing enable aborts any phase, clearing go any phase but the hold-off
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			adcseq_pkg::ST_SAMPLE:
				if (go && enable) // R25
					state_d = rc_sel ? adcseq_pkg::ST_RC_WAIT : // R4
						(acq_tads == 5'd0) ? adcseq_pkg::ST_CONV : adcseq_pkg::ST_ACQ; // R11 R10
			adcseq_pkg::ST_RC_WAIT:
				if (!enable)
					state_d = adcseq_pkg::ST_SAMPLE;
				else if (!go)
					state_d = adcseq_pkg::ST_HOLDOFF;
				else if (cnt_q == 5'(`ADCSEQ_TCY_CYCLES - 1)) // R4
					state_d = (acq_tads == 5'd0) ? adcseq_pkg::ST_CONV : adcseq_pkg::ST_ACQ;
			adcseq_pkg::ST_ACQ:
				if (!enable)
					state_d = adcseq_pkg::ST_SAMPLE;
				else if (!go)
					state_d = adcseq_pkg::ST_HOLDOFF;
				else if (tad_tick && cnt_q == acq_tads - 5'd1) // R10
					state_d = adcseq_pkg::ST_CONV;
			adcseq_pkg::ST_CONV:
				if (!enable)
					state_d = adcseq_pkg::ST_SAMPLE;
				else if (!go || sar_done) // R21
					state_d = adcseq_pkg::ST_HOLDOFF;
			adcseq_pkg::ST_HOLDOFF:
				if (!enable || (tad_tick && cnt_q == 5'(`ADCSEQ_HOLDOFF_TADS - 1))) // R9
					state_d = adcseq_pkg::ST_SAMPLE; // R13
			default:
				state_d = adcseq_pkg::ST_SAMPLE;
		endcase
	end

	// Phase counter: cycles in the RC wait, bit periods elsewhere
	assign cnt_d = (state_d != state_q) ? 5'd0 :
		(st_rc || tad_tick) ? cnt_q + 5'd1 : cnt_q;

	// Start and abort of the approximation engine
	assign sar_start = (state_d == adcseq_pkg::ST_CONV) && !st_conv;
	assign sar_abort = st_conv && (state_d != adcseq_pkg::ST_CONV) && !sar_done; // R21

	adcseq_sar u_sar (
		.ref_clk_i  (ref_clk_i),
		.reset_n_i  (reset_n_i),
		.start_i    (sar_start),
		.abort_i    (sar_abort),
		.tick_i     (tad_tick),
		.comp_i     (comp_i),
		.dac_code_o (sar_code),
		.done_o     (sar_done)
	);

	assign dac_code_o = sar_code;

	// Last bit is decided on the completion edge itself, so resolve it here from the comparator
	assign sar_result   = comp_i ? sar_code : {sar_code[9:1], 1'b0}; // R16

	// Result placement for the two formats
	assign res_high_new = rjust ? {6'h00, sar_result[9:8]} : sar_result[9:2]; // R1 R24
	assign res_low_new  = rjust ? sar_result[7:0] : {sar_result[1:0], 6'h00}; // R1 R24

	// Go: cleared on completion, but a software set in that cycle wins
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (sar_done)
			ctrl_d[`ADCSEQ_BIT_GO] = 1'b0; // R7
		if (wr_ctrl)
			ctrl_d = reg_wdata_i & 8'h3f;
		if (!ctrl_d[`ADCSEQ_BIT_ENABLE])
			ctrl_d[`ADCSEQ_BIT_GO] = 1'b0; // R22 R25
	end

	// Complete flag: hardware set beats a software clear
	assign flag_d = sar_done ? 1'b1 : wr_flags ? reg_wdata_i[`ADCSEQ_BIT_FLAG] : flag_q; // R7

	// Control state; reset switches off and aborts
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q  <= adcseq_pkg::ST_SAMPLE; // R6
			ctrl_q   <= `ADCSEQ_RST_CTRL;
			refpin_q <= `ADCSEQ_RST_REF_PIN;
			timing_q <= `ADCSEQ_RST_TIMING;
			flag_q   <= 1'b0;
			irq_en_q <= 1'b0;
			cnt_q    <= 5'd0;
		end
		else
		begin
			state_q <= state_d;
			ctrl_q  <= ctrl_d;
			flag_q  <= flag_d;
			cnt_q   <= cnt_d;
			if (reg_wr_i && reg_addr_i == `ADCSEQ_OFS_REF_PIN)
				refpin_q <= reg_wdata_i & 8'h3f;
			if (reg_wr_i && reg_addr_i == `ADCSEQ_OFS_TIMING)
				timing_q <= reg_wdata_i & 8'hbf; // R5
			if (wr_flags)
				irq_en_q <= reg_wdata_i[`ADCSEQ_BIT_IRQ_EN];
		end
	end

	// Result pair has no reset so it survives power-up untouched
	always_ff @(posedge ref_clk_i)
	begin
		if (sar_done)
		begin
			res_high_q <= res_high_new; // R7 R8
			res_low_q  <= res_low_new;
		end
		else
		begin
			if (wr_high)
				res_high_q <= reg_wdata_i;
			if (wr_low)
				res_low_q <= reg_wdata_i;
		end
	end

	// Read mux; go shows one phase-free busy bit, unmapped reads zero
	assign rd_mux =
		(reg_addr_i == `ADCSEQ_OFS_RES_HIGH)  ? res_high_q :
		(reg_addr_i == `ADCSEQ_OFS_RES_LOW)   ? res_low_q :
		(reg_addr_i == `ADCSEQ_OFS_CTRL_MAIN) ? ctrl_q : // R14 R22
		(reg_addr_i == `ADCSEQ_OFS_REF_PIN)   ? refpin_q :
		(reg_addr_i == `ADCSEQ_OFS_TIMING)    ? (timing_q & 8'hbf) : // R5
		(reg_addr_i == `ADCSEQ_OFS_FLAGS)     ? {6'h00, irq_en_q, flag_q} : 8'h00;

	// Read data stand for one cycle only
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_q <= 8'h00;
		else
			rdata_q <= reg_rd_i ? rd_mux : 8'h00;
	end

	// Bit periods seen during the current conversion
	logic [3:0] conv_ticks_q;
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			conv_ticks_q <= 4'd0;
		else if (sar_start)
			conv_ticks_q <= 4'd0;
		else if (st_conv && tad_tick)
			conv_ticks_q <= conv_ticks_q + 4'd1;
	end

	// Checks
	a_done_clears_go: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R7
		sar_done && !wr_ctrl |=> !go && flag_q)
		else $error("go not cleared or flag not set on completion");
	a_result_right: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R1
		sar_done && rjust |=> res_low_q == $past(sar_result[7:0]) && res_high_q[7:2] == 6'h00)
		else $error("right-justified result misplaced");
	a_result_left: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R24
		sar_done && !rjust |=> res_high_q == $past(sar_code[9:2]) && res_low_q[5:0] == 6'h00)
		else $error("left-justified result misplaced");
	a_bit6_reads_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R5
		reg_rd_i && reg_addr_i == `ADCSEQ_OFS_TIMING |=> !reg_rdata_o[6])
		else $error("timing bit 6 read nonzero");
	a_manual_conv_now: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R11
		st_sample && go && enable && !rc_sel && acq_sel == 3'b000 |=> st_conv && !sample_closed_o)
		else $error("manual mode did not convert at once");
	a_switch_open_conv: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R15
		st_conv |-> !sample_closed_o)
		else $error("sampling switch closed during conversion");
	a_eleven_tads: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R20
		sar_done |-> conv_ticks_q == 4'd10 && tad_tick)
		else $error("conversion length not eleven bit periods");
	a_holdoff_after: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R9
		st_conv && sar_done && enable |=> st_hold ##1 !st_sample)
		else $error("no two bit period wait after conversion");
	a_disable_stops: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R25
		!enable |=> st_sample && (!go || $past(wr_ctrl)))
		else $error("sequencer active while disabled");
	a_rc_wait_tcy: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R4
		$rose(st_rc) ##0 (go && enable)[*4] |-> st_rc ##1 !st_rc)
		else $error("RC clock wait shorter than one instruction cycle");

	c_manual_done: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sar_done && acq_sel == 3'b000);
	c_timed_done: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sar_done && acq_sel != 3'b000);
	c_abort: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sar_abort);
	c_rc_done: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sar_done && rc_sel);
endmodule // adcseq_top

//--- dv/adcseq_analog_model.sv
// Behavioural model of the sample-and-hold and comparator on one input level
`timescale 1ns/1ps
module adcseq_analog_model (
	input  wire logic       ref_clk_i,
	input  wire logic       sample_closed_i,
	input  wire logic [9:0] level_i,
	input  wire logic [9:0] dac_code_i,
	output logic            comp_o
);
	logic [9:0] held_q;

	// Capacitor follows the pin only while the switch is closed, so late pin moves are invisible
	always_ff @(posedge ref_clk_i)
	begin
		if (sample_closed_i)
			held_q <= level_i;
	end

	// Ideal comparator against the trial code
	assign comp_o = (held_q >= dac_code_i);
endmodule // adcseq_analog_model

//--- dv/adcseq_top_tb.sv
// Self-checking testbench of the converter sequencer
`timescale 1ns/1ps
module adcseq_top_tb;
	localparam int ACQ_TAB [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	localparam int TAD_TAB [8] = '{2, 8, 32, 10, 4, 16, 64, 10};
	logic       ref_clk_i, reset_n_i, reg_wr_i, reg_rd_i, rc_tick_i, comp_i;
	logic       sample_closed_o, converter_enable_o, vref_pos_ext_o, vref_neg_ext_o;
	logic       conv_complete_flag_o, conv_complete_irq_en_o;
	logic [2:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, d, eh, el;
	logic [9:0] dac_code_o, level;
	logic [3:0] channel_select_o, pin_cfg_o;
	logic [31:0] seed;
	int         n_mismatch, n_checks;
	int         rc_cnt = 0;
	int         q [$];

	adcseq_top DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.rc_tick_i(rc_tick_i), .comp_i(comp_i), .dac_code_o(dac_code_o), .channel_select_o(channel_select_o),
		.sample_closed_o(sample_closed_o), .converter_enable_o(converter_enable_o),
		.vref_pos_ext_o(vref_pos_ext_o), .vref_neg_ext_o(vref_neg_ext_o), .pin_cfg_o(pin_cfg_o),
		.conv_complete_flag_o(conv_complete_flag_o), .conv_complete_irq_en_o(conv_complete_irq_en_o));
	adcseq_analog_model u_analog (.ref_clk_i(ref_clk_i), .sample_closed_i(sample_closed_o),
		.level_i(level), .dac_code_i(dac_code_o), .comp_o(comp_i));

	// Free-running clock
	initial
	begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// RC converter clock stand-in, one tick every ten clocks
	always @(posedge ref_clk_i)
	begin
		rc_cnt <= (rc_cnt == 9) ? 0 : rc_cnt + 1;
		rc_tick_i <= (rc_cnt == 9);
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t value got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi)
		begin
			n_mismatch++;
			$display("[FAIL] %0t duration %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// Wait n edges, then let their updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge ref_clk_i);
		v = reg_rdata_o;
	endtask

	// One conversion with clock code i, acquisition code i, justification i[0]
	task automatic do_conv(input int i);
		int tad, acq, v, t0, k;
		logic [3:0] ch;
		tad = TAD_TAB[i];
		acq = ACQ_TAB[i];
		v = xs() % 1024;
		ch = 4'(xs() % 13);
		level <= v[9:0];
		q.push_back(v);
		wr(3'h4, {i[0], 1'b0, i[2:0], i[2:0]});
		wr(3'h2, {2'b00, ch, 2'b01});
		cyc(40);
		chk_val(channel_select_o, ch);
		wr(3'h2, {2'b00, ch, 2'b11});
		t0 = $time;
		cyc(tad);
		chk_val(sample_closed_o, acq != 0);
		k = 0;
		while (sample_closed_o !== 1'b0 && k < 3000)
		begin
			cyc(1);
			k++;
		end
		// Pin moves once the switch is open; the result must not follow it
		level <= ~v[9:0];
		rd(3'h2, d);
		chk_val(d[1], 1'b1);
		k = 0;
		while (d[1] !== 1'b0 && k < 3000)
		begin
			rd(3'h2, d);
			k++;
		end
		chk_rng((int'($time) - t0) / 20, (acq + 10) * tad, (acq + 13) * tad + 16);
		if (tad >= 8)
			chk_val(sample_closed_o, 1'b0);
		k = 0;
		while (sample_closed_o !== 1'b1 && k < 3 * tad + 8)
		begin
			cyc(1);
			k++;
		end
		chk_val(sample_closed_o, 1'b1);
		v = q.pop_front();
		eh = i[0] ? {6'h00, v[9:8]} : v[9:2];
		el = i[0] ? v[7:0] : {v[1:0], 6'h00};
		rd(3'h0, d);
		chk_val(d, eh);
		rd(3'h1, d);
		chk_val(d, el);
		chk_val(conv_complete_flag_o, 1'b1);
		rd(3'h5, d);
		chk_val(d[0], 1'b1);
		wr(3'h5, 8'h00);
	endtask

	// Main sequence
	initial
	begin
		reset_n_i = 1'b0;
		reg_addr_i = 3'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		level = 10'h000;
		seed = 32'h0000_05E6;
		n_mismatch = 0;
		n_checks = 0;
		cyc(4);
		reset_n_i <= 1'b1;
		for (int a = 2; a < 8; a++)
		begin
			rd(a[2:0], d);
			chk_val(d, 8'h00);
		end
		wr(3'h4, 8'hFF);
		rd(3'h4, d);
		chk_val(d, 8'hBF);
		wr(3'h3, 8'h3F);
		cyc(1);
		chk_val({vref_neg_ext_o, vref_pos_ext_o, pin_cfg_o}, 6'h3F);
		wr(3'h5, 8'h02);
		cyc(1);
		chk_val(conv_complete_irq_en_o, 1'b1);
		wr(3'h2, 8'h02);
		rd(3'h2, d);
		chk_val(d, 8'h00);
		chk_val(sample_closed_o, 1'b0);
		for (int i = 0; i < 8; i++)
			do_conv(i);
		// Abort in mid conversion keeps the old result and raises no flag
		wr(3'h4, 8'h06);
		wr(3'h2, 8'h03);
		cyc(100);
		wr(3'h2, 8'h01);
		rd(3'h2, d);
		chk_val(d, 8'h01);
		cyc(300);
		rd(3'h0, d);
		chk_val(d, eh);
		rd(3'h1, d);
		chk_val(d, el);
		rd(3'h5, d);
		chk_val(d[0], 1'b0);
		// Reset in mid conversion
		wr(3'h2, 8'h03);
		cyc(50);
		reset_n_i <= 1'b0;
		cyc(4);
		chk_val({converter_enable_o, sample_closed_o}, 2'b00);
		chk_val(dac_code_o, 10'h000);
		reset_n_i <= 1'b1;
		rd(3'h2, d);
		chk_val(d, 8'h00);
		rd(3'h4, d);
		chk_val(d, 8'h00);
		rd(3'h0, d);
		chk_val(d, eh);
		rd(3'h1, d);
		chk_val(d, el);
		end_of_test();
	end

	// Watchdog, well past the longest expected run
	initial
	begin
		#1_000_000;
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
endmodule // adcseq_top_tb
